// ==== inc/io_clock_config_params.svh ====
/*
 * Offsets, field positions, reset values and levels of the two I/O and clock
 * configuration registers.
 * Assumes inclusion by bare name from files that need these constants.
 */
`ifndef IO_CLOCK_CONFIG_PARAMS_SVH
`define IO_CLOCK_CONFIG_PARAMS_SVH

// register indices; byte address is four times the index
`define CFG_ONE_INDEX 8'h00
`define CFG_TWO_INDEX 8'h01
`define CFG_INDEX_MSB 9
`define CFG_INDEX_LSB 2

// first register fields
`define CFG_ONE_SINGLE_DRIVE 7
`define CFG_ONE_ALT_DRIVER 6
`define CFG_ONE_RX_LEVEL 5
`define CFG_ONE_TX_LEVEL 4
`define CFG_ONE_CRYSTAL 3
`define CFG_ONE_DIV_HI 2
`define CFG_ONE_DIV_LO 1
`define CFG_ONE_SLOW_OFF 0

// second register fields
`define CFG_TWO_LOW_SUPPLY 7
`define CFG_TWO_RAIL_OFF 6
`define CFG_TWO_PD_ACTIVE 4
`define CFG_TWO_PD_IDLE 3
`define CFG_TWO_DRIVE_BOOST 2
`define CFG_TWO_SLOW_RAMP 0

// power-up values and writable bits
`define CFG_ONE_RESET 8'h08
`define CFG_TWO_RESET 8'h00
`define CFG_ONE_WMASK 8'hff
`define CFG_TWO_WMASK 8'hdd

// fifo water levels in bytes
`define RX_LEVEL_LOW 7'h40
`define RX_LEVEL_HIGH 7'h50
`define TX_LEVEL_LOW 7'h20
`define TX_LEVEL_HIGH 7'h10

`endif

// ==== inc/io_clock_config_pkg.sv ====
/*
 * Types shared by the configuration register bank and its clock output mux.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package io_clock_config_pkg;
   typedef enum logic [1:0] {
      host_clk_slow = 2'b00,
      host_clk_mid = 2'b01,
      host_clk_fast = 2'b10,
      host_clk_off = 2'b11
   } host_clk_sel_e;

   typedef enum logic [1:0] {
      resp_okay = 2'b00,
      resp_slverr = 2'b10
   } axi_resp_e;
endpackage : io_clock_config_pkg

// ==== inc/host_clk_cfg_if.sv ====
/*
 * Clock output settings passed from the register bank to the clock mux.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps
interface host_clk_cfg_if;
   import io_clock_config_pkg::*;
   host_clk_sel_e sel;
   logic slow_clock_suppress;
   modport src (output sel, output slow_clock_suppress);
   modport sink (input sel, input slow_clock_suppress);
endinterface : host_clk_cfg_if

// ==== src/host_clock_mux.sv ====
/*
 * Host clock output selection: crystal-derived rates, the slow clock or low.
 * Assumes the crystal-derived rates and the slow clock arrive as levels
 * synchronous to i_clock, made by the oscillator block.
 */
`timescale 1ns/1ps
module host_clock_mux
   import io_clock_config_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_nrst,
   host_clk_cfg_if.sink cfg,
   input wire logic i_xtal_running,
   input wire logic [2:0] i_xtal_clk,
   input wire logic i_lf_clk,
   output logic o_host_clk
);
   logic host_clk_d;
   logic host_clk_q;

   always_comb begin
      host_clk_d = 1'b0;
      if (cfg.sel == host_clk_off) begin
         host_clk_d = 1'b0; // see [RL7]
      end else if (i_xtal_running) begin
         unique case (cfg.sel)
            host_clk_slow: host_clk_d = i_xtal_clk[0]; // see [RL7]
            host_clk_mid: host_clk_d = i_xtal_clk[1]; // see [RL7]
            host_clk_fast: host_clk_d = i_xtal_clk[2]; // see [RL7]
            host_clk_off: host_clk_d = 1'b0;
         endcase
      end else begin
         // slow clock stands in while the crystal is down
         host_clk_d = i_lf_clk & ~cfg.slow_clock_suppress; // see [RL8] see [RL9]
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         host_clk_q <= 1'b0;
      end else begin
         host_clk_q <= host_clk_d;
      end
   end

   assign o_host_clk = host_clk_q;
endmodule : host_clock_mux

// ==== src/io_clock_config_regs.sv ====
/*
 * I/O and clock configuration register bank with an AXI4-Lite slave port.
 * Assumes i_nrst is the power-up reset only, all inputs are synchronous to
 * i_clock, and the consumers of the decoded settings sit outside.
 */
//
// Contract
// [RL1] single-drive set uses one antenna driver, clear drives both differentially.
// [RL2] in single drive the select bit picks driver a and its input at 0, driver b at 1.
// [RL3] receive water level is 64 bytes at 0 and 80 bytes at 1.
// [RL4] transmit water level is 32 bytes at 0 and 16 bytes at 1.
// [RL5] crystal select means 13.56 MHz at 0 and 27.12 MHz at 1, power-up value 1.
// [RL6] software may use very high bit rates only with the 27.12 MHz crystal.
// [RL7] with the crystal running the host clock is 3.39, 6.78, 13.56 MHz or held low.
// [RL8] with the crystal stopped and the output not disabled the slow clock goes out.
// [RL9] the slow-clock-off bit keeps the slow clock off the host clock output.
// [RL10] both registers take their defaults at power-up only.
// [RL11] supply select means the 5 V range at 0 and the 3.3 V range at 1.
// [RL12] the rail-off bit disables the internal digital supply regulator.
// [RL13] active pull-down bit pulls serial out down while selected and not driven.
// [RL14] idle pull-down bit pulls serial out down while chip select is high.
// [RL15] the drive-boost bit raises serial out drive strength for a 1.8 V supply.
// [RL16] the slow-ramp bit ramps the transmitter slowly at switch-on.
// [RL17] unused bits of the second register ignore writes and read zero.
`timescale 1ns/1ps
`include "io_clock_config_params.svh"
module io_clock_config_regs
   import io_clock_config_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic [ADDR_W-1:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [ADDR_W-1:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   input wire logic i_xtal_running,
   input wire logic [2:0] i_xtal_clk,
   input wire logic i_lf_clk,
   input wire logic i_cs_n,
   input wire logic i_sdo_oe,
   output logic o_single_drive,
   output logic o_antenna_driver_a,
   output logic o_antenna_driver_b,
   output logic o_alt_driver_select,
   output logic [6:0] o_rx_water_level,
   output logic [6:0] o_tx_water_level,
   output logic o_crystal_freq_select,
   output logic o_very_high_bit_rate_ok,
   output logic o_host_clk,
   output logic o_low_supply_select,
   output logic o_digital_supply_rail_off,
   output logic o_sdo_pulldown,
   output logic o_sdo_drive_boost,
   output logic o_tx_slow_ramp
);
   host_clk_cfg_if clk_cfg ();

   // configuration storage
   logic [7:0] cfg_one_d;
   logic [7:0] cfg_one_q;
   logic [7:0] cfg_two_d;
   logic [7:0] cfg_two_q;

   // write channel state
   logic aw_got_d;
   logic aw_got_q;
   logic w_got_d;
   logic w_got_q;
   logic [ADDR_W-1:0] waddr_d;
   logic [ADDR_W-1:0] waddr_q;
   logic [7:0] wbyte_d;
   logic [7:0] wbyte_q;
   logic wlane_d;
   logic wlane_q;
   logic awready_d;
   logic awready_q;
   logic wready_d;
   logic wready_q;
   logic bvalid_d;
   logic bvalid_q;
   axi_resp_e bresp_d;
   axi_resp_e bresp_q;

   // read channel state
   logic arready_d;
   logic arready_q;
   logic rvalid_d;
   logic rvalid_q;
   logic [31:0] rdata_d;
   logic [31:0] rdata_q;
   axi_resp_e rresp_d;
   axi_resp_e rresp_q;

   // decoded outputs
   logic single_d;
   logic single_q;
   logic drv_a_d;
   logic drv_a_q;
   logic drv_b_d;
   logic drv_b_q;
   logic alt_d;
   logic alt_q;
   logic [6:0] rx_lvl_d;
   logic [6:0] rx_lvl_q;
   logic [6:0] tx_lvl_d;
   logic [6:0] tx_lvl_q;
   logic xtal_d;
   logic xtal_q;
   logic very_high_bit_rate_d;
   logic very_high_bit_rate_q;
   logic low_sup_d;
   logic low_sup_q;
   logic rail_off_d;
   logic rail_off_q;
   logic pd_d;
   logic pd_q;
   logic boost_d;
   logic boost_q;
   logic ramp_d;
   logic ramp_q;

   // 0: unmapped, 1: first register, 2: second register
   function automatic logic [1:0] decode(input logic [ADDR_W-1:0] addr);
      logic [7:0] idx;
      idx = 8'(addr[`CFG_INDEX_MSB:`CFG_INDEX_LSB]);
      decode = 2'h0;
      if (addr[ADDR_W-1:`CFG_INDEX_MSB+1] == '0 && addr[1:0] == 2'h0) begin
         if (idx == `CFG_ONE_INDEX) begin
            decode = 2'h1;
         end else if (idx == `CFG_TWO_INDEX) begin
            decode = 2'h2;
         end
      end
   endfunction : decode

   // bus slave: address and data taken in either order, one write at a time
   always_comb begin
      aw_got_d = aw_got_q;
      w_got_d = w_got_q;
      waddr_d = waddr_q;
      wbyte_d = wbyte_q;
      wlane_d = wlane_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      cfg_one_d = cfg_one_q;
      cfg_two_d = cfg_two_q;
      if (i_awvalid && awready_q) begin
         aw_got_d = 1'b1;
         waddr_d = i_awaddr;
      end
      if (i_wvalid && wready_q) begin
         w_got_d = 1'b1;
         wbyte_d = i_wdata[7:0];
         wlane_d = i_wstrb[0];
      end
      if (bvalid_q && i_bready) begin
         bvalid_d = 1'b0;
      end
      if (aw_got_q && w_got_q && !bvalid_q) begin
         aw_got_d = 1'b0;
         w_got_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = resp_okay;
         unique case (decode(waddr_q))
            2'h1: begin
               if (wlane_q) begin
                  cfg_one_d = wbyte_q & `CFG_ONE_WMASK;
               end
            end
            2'h2: begin
               if (wlane_q) begin
                  cfg_two_d = wbyte_q & `CFG_TWO_WMASK; // see [RL17]
               end
            end
            default: bresp_d = resp_slverr;
         endcase
      end
      awready_d = !aw_got_d;
      wready_d = !w_got_d;
   end

   // read path: one beat outstanding, data registered
   always_comb begin
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (rvalid_q && i_rready) begin
         rvalid_d = 1'b0;
      end
      if (i_arvalid && arready_q) begin
         rvalid_d = 1'b1;
         rdata_d = 32'h0;
         rresp_d = resp_okay;
         unique case (decode(i_araddr))
            2'h1: rdata_d = {24'h0, cfg_one_q};
            2'h2: rdata_d = {24'h0, cfg_two_q}; // see [RL17]
            default: rresp_d = resp_slverr;
         endcase
      end
      arready_d = !rvalid_d;
   end

   // settings decode, registered so each output leaves a flip-flop
   always_comb begin
      single_d = cfg_one_q[`CFG_ONE_SINGLE_DRIVE]; // see [RL1]
      alt_d = cfg_one_q[`CFG_ONE_ALT_DRIVER]; // see [RL2]
      drv_a_d = !single_d || !alt_d; // see [RL1] see [RL2]
      drv_b_d = !single_d || alt_d; // see [RL1] see [RL2]
      rx_lvl_d = cfg_one_q[`CFG_ONE_RX_LEVEL] ? `RX_LEVEL_HIGH : `RX_LEVEL_LOW; // see [RL3]
      tx_lvl_d = cfg_one_q[`CFG_ONE_TX_LEVEL] ? `TX_LEVEL_HIGH : `TX_LEVEL_LOW; // see [RL4]
      xtal_d = cfg_one_q[`CFG_ONE_CRYSTAL]; // see [RL5]
      // software checks this before picking the fastest rates
      very_high_bit_rate_d = cfg_one_q[`CFG_ONE_CRYSTAL]; // see [RL6]
      low_sup_d = cfg_two_q[`CFG_TWO_LOW_SUPPLY]; // see [RL11]
      rail_off_d = cfg_two_q[`CFG_TWO_RAIL_OFF]; // see [RL12]
      pd_d = (cfg_two_q[`CFG_TWO_PD_ACTIVE] && !i_cs_n && !i_sdo_oe) // see [RL13]
         || (cfg_two_q[`CFG_TWO_PD_IDLE] && i_cs_n); // see [RL14]
      boost_d = cfg_two_q[`CFG_TWO_DRIVE_BOOST]; // see [RL15]
      ramp_d = cfg_two_q[`CFG_TWO_SLOW_RAMP]; // see [RL16]
   end

   // i_nrst is power-up only; no other event reloads the defaults
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         cfg_one_q <= `CFG_ONE_RESET; // see [RL10] see [RL5]
         cfg_two_q <= `CFG_TWO_RESET; // see [RL10]
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         waddr_q <= '0;
         wbyte_q <= 8'h00;
         wlane_q <= 1'b0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= resp_okay;
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= resp_okay;
         single_q <= 1'b0;
         drv_a_q <= 1'b1;
         drv_b_q <= 1'b1;
         alt_q <= 1'b0;
         rx_lvl_q <= `RX_LEVEL_LOW;
         tx_lvl_q <= `TX_LEVEL_LOW;
         xtal_q <= 1'b1;
         very_high_bit_rate_q <= 1'b1;
         low_sup_q <= 1'b0;
         rail_off_q <= 1'b0;
         pd_q <= 1'b0;
         boost_q <= 1'b0;
         ramp_q <= 1'b0;
      end else begin
         cfg_one_q <= cfg_one_d;
         cfg_two_q <= cfg_two_d;
         aw_got_q <= aw_got_d;
         w_got_q <= w_got_d;
         waddr_q <= waddr_d;
         wbyte_q <= wbyte_d;
         wlane_q <= wlane_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
         single_q <= single_d;
         drv_a_q <= drv_a_d;
         drv_b_q <= drv_b_d;
         alt_q <= alt_d;
         rx_lvl_q <= rx_lvl_d;
         tx_lvl_q <= tx_lvl_d;
         xtal_q <= xtal_d;
         very_high_bit_rate_q <= very_high_bit_rate_d;
         low_sup_q <= low_sup_d;
         rail_off_q <= rail_off_d;
         pd_q <= pd_d;
         boost_q <= boost_d;
         ramp_q <= ramp_d;
      end
   end

   assign clk_cfg.sel = host_clk_sel_e'({cfg_one_q[`CFG_ONE_DIV_HI],
                                         cfg_one_q[`CFG_ONE_DIV_LO]}); // see [RL7]
   assign clk_cfg.slow_clock_suppress = cfg_one_q[`CFG_ONE_SLOW_OFF]; // see [RL9]

   host_clock_mux u_host_clock_mux (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .cfg(clk_cfg.sink),
      .i_xtal_running(i_xtal_running),
      .i_xtal_clk(i_xtal_clk),
      .i_lf_clk(i_lf_clk),
      .o_host_clk(o_host_clk)
   );

   assign o_awready = awready_q;
   assign o_wready = wready_q;
   assign o_bvalid = bvalid_q;
   assign o_bresp = bresp_q;
   assign o_arready = arready_q;
   assign o_rvalid = rvalid_q;
   assign o_rdata = rdata_q;
   assign o_rresp = rresp_q;
   assign o_single_drive = single_q;
   assign o_antenna_driver_a = drv_a_q;
   assign o_antenna_driver_b = drv_b_q;
   assign o_alt_driver_select = alt_q;
   assign o_rx_water_level = rx_lvl_q;
   assign o_tx_water_level = tx_lvl_q;
   assign o_crystal_freq_select = xtal_q;
   assign o_very_high_bit_rate_ok = very_high_bit_rate_q;
   assign o_low_supply_select = low_sup_q;
   assign o_digital_supply_rail_off = rail_off_q;
   assign o_sdo_pulldown = pd_q;
   assign o_sdo_drive_boost = boost_q;
   assign o_tx_slow_ramp = ramp_q;
endmodule : io_clock_config_regs

// ==== verif/io_clock_config_regs_sva.sv ====
/* checker for io_clock_config_regs: bus timing and decoded setting outputs.
   assumes one clock and i_nrst as the only reset. */
`timescale 1ns/1ps
module io_clock_config_regs_sva (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_awvalid,
   input wire logic o_awready,
   input wire logic i_wvalid,
   input wire logic o_wready,
   input wire logic o_bvalid,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic o_rvalid,
   input wire logic i_xtal_running,
   input wire logic [2:0] i_xtal_clk,
   input wire logic i_lf_clk,
   input wire logic i_cs_n,
   input wire logic i_sdo_oe,
   input wire logic o_single_drive,
   input wire logic o_antenna_driver_a,
   input wire logic o_antenna_driver_b,
   input wire logic o_alt_driver_select,
   input wire logic [6:0] o_rx_water_level,
   input wire logic [6:0] o_tx_water_level,
   input wire logic o_crystal_freq_select,
   input wire logic o_very_high_bit_rate_ok,
   input wire logic o_host_clk,
   input wire logic o_sdo_pulldown
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_nrst);
   property p_diff;
      !o_single_drive |-> o_antenna_driver_a && o_antenna_driver_b;
   endproperty
   a_diff: assert property (p_diff) else $error("both drivers not on");
   property p_single;
      o_single_drive |-> o_antenna_driver_b == o_alt_driver_select
         && o_antenna_driver_a != o_alt_driver_select;
   endproperty
   a_single: assert property (p_single) else $error("wrong single driver");
   property p_rx;
      o_rx_water_level == 7'h40 || o_rx_water_level == 7'h50;
   endproperty
   a_rx: assert property (p_rx) else $error("bad rx level");
   property p_tx;
      o_tx_water_level == 7'h20 || o_tx_water_level == 7'h10;
   endproperty
   a_tx: assert property (p_tx) else $error("bad tx level");
   property p_very_high_bit_rate;
      o_very_high_bit_rate_ok == o_crystal_freq_select;
   endproperty
   a_very_high_bit_rate: assert property (p_very_high_bit_rate) else $error("very_high_bit_rate permit mismatch");
   property p_por;
      $rose(i_nrst) |-> o_crystal_freq_select && !o_single_drive
         && o_rx_water_level == 7'h40 && o_tx_water_level == 7'h20;
   endproperty
   a_por: assert property (p_por) else $error("power-up values wrong");
   property p_xoff;
      i_xtal_running && i_xtal_clk == 3'b000 |=> !o_host_clk;
   endproperty
   a_xoff: assert property (p_xoff) else $error("host clock not from crystal");
   property p_lf;
      !i_xtal_running && !i_lf_clk |=> !o_host_clk;
   endproperty
   a_lf: assert property (p_lf) else $error("host clock not slow clock");
   property p_pd;
      !i_cs_n && i_sdo_oe |=> !o_sdo_pulldown;
   endproperty
   a_pd: assert property (p_pd) else $error("pull-down while driving");
   property p_wr;
      i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid;
   endproperty
   a_wr: assert property (p_wr) else $error("write response late");
   property p_rd;
      i_arvalid && o_arready |=> o_rvalid && !o_arready;
   endproperty
   a_rd: assert property (p_rd) else $error("read answer late");
   c_wr: cover property (i_awvalid && o_awready ##2 o_bvalid);
   c_rd: cover property (i_arvalid && o_arready ##1 o_rvalid);
   c_single: cover property (o_single_drive && o_antenna_driver_b);
   c_lf: cover property (!i_xtal_running && o_host_clk);
endmodule : io_clock_config_regs_sva

bind io_clock_config_regs io_clock_config_regs_sva u_sva (
   .i_clock, .i_nrst, .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bvalid,
   .i_arvalid, .o_arready, .o_rvalid, .i_xtal_running, .i_xtal_clk, .i_lf_clk,
   .i_cs_n, .i_sdo_oe, .o_single_drive, .o_antenna_driver_a, .o_antenna_driver_b,
   .o_alt_driver_select, .o_rx_water_level, .o_tx_water_level,
   .o_crystal_freq_select, .o_very_high_bit_rate_ok, .o_host_clk, .o_sdo_pulldown
);

// ==== verif/io_clock_config_regs_bench.sv ====
/* self-checking bench for io_clock_config_regs over AXI4-Lite.
   assumes the design package is compiled first. */
`timescale 1ns/1ps
module io_clock_config_regs_bench
   import io_clock_config_pkg::*;
;
   logic i_clock = 1'b0, i_nrst = 1'b0, i_awvalid = 1'b0, i_wvalid = 1'b0;
   logic i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0, i_lf_clk = 1'b0;
   logic i_xtal_running = 1'b1, i_cs_n = 1'b1, i_sdo_oe = 1'b0;
   logic [11:0] i_awaddr = 12'h000, i_araddr = 12'h000;
   logic [31:0] i_wdata = 32'h0, o_rdata;
   logic [3:0] i_wstrb = 4'h0;
   logic [2:0] i_xtal_clk = 3'b000;
   logic [1:0] o_bresp, o_rresp;
   logic [6:0] o_rx_water_level, o_tx_water_level;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_single_drive;
   logic o_antenna_driver_a, o_antenna_driver_b, o_alt_driver_select;
   logic o_crystal_freq_select, o_very_high_bit_rate_ok, o_host_clk;
   logic o_low_supply_select, o_digital_supply_rail_off, o_sdo_pulldown;
   logic o_sdo_drive_boost, o_tx_slow_ramp;
   int fail_count = 0;
   int n_checks = 0;

   io_clock_config_regs #(.ADDR_W(12)) dut (
      .i_clock, .i_nrst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
      .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
      .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_xtal_running,
      .i_xtal_clk, .i_lf_clk, .i_cs_n, .i_sdo_oe, .o_single_drive, .o_antenna_driver_a,
      .o_antenna_driver_b, .o_alt_driver_select, .o_rx_water_level, .o_tx_water_level,
      .o_crystal_freq_select, .o_very_high_bit_rate_ok, .o_host_clk,
      .o_low_supply_select, .o_digital_supply_rail_off, .o_sdo_pulldown,
      .o_sdo_drive_boost, .o_tx_slow_ramp
   );

   always #5 i_clock = ~i_clock;

   task automatic tally_and_finish;
      if (fail_count == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic hang(input int n);
      if (n >= 50) begin
         fail_count++;
         tally_and_finish();
      end
   endtask : hang

   // settle past the edge so registered outputs have landed
   task automatic st(input int k);
      repeat (k) @(posedge i_clock);
      #1;
   endtask : st

   task automatic power_up;
      i_nrst <= 1'b0;
      repeat (10) @(posedge i_clock);
      i_nrst <= 1'b1;
   endtask : power_up

   // bready is raised with the request; holding it early is legal
   task automatic wr(input logic [11:0] a, input logic [7:0] d,
         input logic [3:0] s, input logic [1:0] r);
      int n;
      @(posedge i_clock);
      i_awaddr <= a;
      i_awvalid <= 1'b1;
      i_wdata <= {24'h0, d};
      i_wstrb <= s;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge i_clock);
         if (o_awready) i_awvalid <= 1'b0;
         if (o_wready) i_wvalid <= 1'b0;
         if (o_bvalid) break;
      end
      hang(n);
      chk(o_bresp, r);
      i_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      @(posedge i_clock);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge i_clock);
         if (o_arready) i_arvalid <= 1'b0;
         if (o_rvalid) break;
      end
      hang(n);
      chk(o_rdata, d);
      chk(o_rresp, r);
      i_rready <= 1'b0;
   endtask : rd

   task automatic hc(input logic run, input logic [2:0] xc, input logic lf, input logic e);
      @(posedge i_clock);
      i_xtal_running <= run;
      i_xtal_clk <= xc;
      i_lf_clk <= lf;
      st(2);
      chk(o_host_clk, e);
   endtask : hc

   task automatic pd(input logic cs, input logic oe, input logic e);
      @(posedge i_clock);
      i_cs_n <= cs;
      i_sdo_oe <= oe;
      st(2);
      chk(o_sdo_pulldown, e);
   endtask : pd

   task automatic t_defaults;
      rd(12'h000, 32'h08, resp_okay);
      rd(12'h004, 32'h00, resp_okay);
      chk(o_single_drive, 1'b0);
      chk(o_rx_water_level, 7'h40);
      chk(o_tx_water_level, 7'h20);
   endtask : t_defaults

   task automatic t_drive;
      wr(12'h000, 8'hf0, 4'h1, resp_okay);
      rd(12'h000, 32'hf0, resp_okay);
      chk(o_alt_driver_select, 1'b1);
      chk(o_antenna_driver_a, 1'b0);
      chk(o_antenna_driver_b, 1'b1);
      chk(o_rx_water_level, 7'h50);
      chk(o_tx_water_level, 7'h10);
      chk(o_crystal_freq_select, 1'b0);
      chk(o_very_high_bit_rate_ok, 1'b0);
      wr(12'h000, 8'h80, 4'h1, resp_okay);
      st(1);
      chk(o_alt_driver_select, 1'b0);
      chk(o_antenna_driver_a, 1'b1);
      chk(o_antenna_driver_b, 1'b0);
      wr(12'h000, 8'h78, 4'h1, resp_okay);
      st(1);
      chk({o_single_drive, o_antenna_driver_a, o_antenna_driver_b}, 3'b011);
      chk(o_crystal_freq_select, 1'b1);
      chk(o_very_high_bit_rate_ok, 1'b1);
   endtask : t_drive

   task automatic t_host;
      for (int f = 0; f < 3; f++) begin
         wr(12'h000, {5'b00001, f[1:0], 1'b0}, 4'h1, resp_okay);
         hc(1'b1, 3'b001 << f, 1'b0, 1'b1);
         hc(1'b1, ~(3'b001 << f), 1'b1, 1'b0);
      end
      wr(12'h000, 8'h0e, 4'h1, resp_okay);
      hc(1'b1, 3'b111, 1'b1, 1'b0);
      // a disabled output must also hide the slow clock
      hc(1'b0, 3'b111, 1'b1, 1'b0);
      wr(12'h000, 8'h08, 4'h1, resp_okay);
      hc(1'b0, 3'b000, 1'b1, 1'b1);
      wr(12'h000, 8'h09, 4'h1, resp_okay);
      hc(1'b0, 3'b000, 1'b1, 1'b0);
   endtask : t_host

   task automatic t_cfg2;
      wr(12'h004, 8'hff, 4'h1, resp_okay);
      rd(12'h004, 32'hdd, resp_okay);
      chk(o_low_supply_select, 1'b1);
      chk(o_digital_supply_rail_off, 1'b1);
      chk(o_sdo_drive_boost, 1'b1);
      chk(o_tx_slow_ramp, 1'b1);
      pd(1'b1, 1'b1, 1'b1);
      pd(1'b0, 1'b0, 1'b1);
      pd(1'b0, 1'b1, 1'b0);
      wr(12'h004, 8'h08, 4'h1, resp_okay);
      pd(1'b0, 1'b0, 1'b0);
      pd(1'b1, 1'b0, 1'b1);
      wr(12'h004, 8'h10, 4'h1, resp_okay);
      st(1);
      chk({o_low_supply_select, o_digital_supply_rail_off}, 2'b00);
      chk({o_sdo_drive_boost, o_tx_slow_ramp}, 2'b00);
      pd(1'b1, 1'b0, 1'b0);
      pd(1'b0, 1'b0, 1'b1);
   endtask : t_cfg2

   // unmapped, misaligned, aliased and lane-less writes must leave both registers
   task automatic t_refuse;
      wr(12'h008, 8'hff, 4'h1, resp_slverr);
      wr(12'h002, 8'hff, 4'h1, resp_slverr);
      wr(12'h400, 8'hff, 4'h1, resp_slverr);
      wr(12'h000, 8'h55, 4'h0, resp_okay);
      rd(12'h008, 32'h0, resp_slverr);
      rd(12'h000, 32'h09, resp_okay);
      rd(12'h004, 32'h10, resp_okay);
   endtask : t_refuse

   initial begin
      power_up();
      t_defaults();
      t_drive();
      t_host();
      t_cfg2();
      t_refuse();
      power_up();
      t_defaults();
      tally_and_finish();
   end
endmodule : io_clock_config_regs_bench
